// file: rcs_consts.svh
`ifndef RCS_CONSTS_SVH
`define RCS_CONSTS_SVH
// Register word offsets (bus byte address divided by four)
`define RCS_OFF_STATUS   4'h0
`define RCS_OFF_PWRCTL   4'h1
`define RCS_OFF_PCHIGH   4'h2
`define RCS_OFF_IRQCTL   4'h3
`define RCS_OFF_PERIPH_IRQ_FLAGS1     4'h4
`define RCS_OFF_PERIPH_IRQ_FLAGS2     4'h5
`define RCS_OFF_DATA0    4'h6
`define RCS_OFF_EVTSTAT  4'hA
`define RCS_OFF_EVTMASK  4'hB
`define RCS_DATA_REGS    4
// Field positions
`define RCS_ST_TO        4
`define RCS_ST_PD        3
`define RCS_PC_POR       1
`define RCS_PC_BOR       0
`define RCS_IC_GIE       7
// Reset values and vectors
`define RCS_RST_VEC      13'h0000
`define RCS_IRQ_VEC      13'h0004
`define RCS_EVT_RST      6'h01
`define RCS_EVT_W        6
`endif

// file: rcs_pkg.sv
package rcs_pkg;
    // Reset and wake causes after priority resolution
    typedef struct packed {
        logic irqWake;
        logic wdtWake;
        logic wdtRst;
        logic master_clear_pin;
        logic bor;
        logic por;
    } rcs_cause_t;

    // Core status byte layout
    typedef struct packed {
        logic [2:0] bank;
        logic       timeoutFlag;
        logic       powerdownFlag;
        logic [2:0] alu;
    } rcs_status_t;

    // Program counter sequencing states
    typedef enum logic [2:0] {
        RCS_RUN   = 3'b001,
        RCS_SLEEP = 3'b010,
        RCS_VECT  = 3'b100
    } rcs_state_t;
endpackage

// file: rcs_evt_irq.sv
`timescale 1ns/1ps
`include "rcs_consts.svh"
module rcs_evt_irq
    import rcs_pkg::*;
#(
    parameter int W = `RCS_EVT_W
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // Events and software access
    input  wire logic [W-1:0] evtSet,
    input  wire logic         clrWr,
    input  wire logic [W-1:0] clrData,
    input  wire logic         maskWr,
    input  wire logic [W-1:0] maskData,
    // State and interrupt
    output logic      [W-1:0] evtStatus,
    output logic      [W-1:0] evtMask,
    output logic              irq
);
    // Sticky bits, set wins over write-one-to-clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            evtStatus <= W'(`RCS_EVT_RST);
        end else begin
            evtStatus <= (evtStatus & ~(clrWr ? clrData : '0)) | evtSet;
        end
    end

    // Mask register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            evtMask <= '0;
        end else if (maskWr) begin
            evtMask <= maskData;
        end
    end

    // Level interrupt
    assign irq = |(evtStatus & evtMask);

    sticky_set_a: assert property (@(posedge clk) disable iff (!rst_n)
        |evtSet |=> (evtStatus & $past(evtSet)) == $past(evtSet))
        else $error("event bit lost");
endmodule // rcs_evt_irq

// file: rcs_reset_cause.sv
// Design decisions made here: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ps
`include "rcs_consts.svh"
module rcs_reset_cause
    import rcs_pkg::*;
#(
    parameter bit HAS_PWRCTL = 1'b1,
    parameter bit HAS_BOR    = 1'b1,
    parameter int PC_W       = 13
) (
    // Clock and power-on reset
    input  wire logic            clk,
    input  wire logic            rst_n,
    // Reset and wake sources, one-cycle pulses
    input  wire logic            borReq,
    input  wire logic            brownoutDetectEnable,
    input  wire logic            masterClearReq,
    input  wire logic            watchdogTimeout,
    input  wire logic            irqWakeReq,
    input  wire logic [7:0]      wakeIrqCtrlFlags,
    input  wire logic [7:0]      wakePir1Flags,
    input  wire logic [7:0]      wakePir2Flags,
    // Core sequencing
    input  wire logic            sleepEnter,
    input  wire logic [PC_W-1:0] pcNow,
    input  wire logic            instrDone,
    output logic                 pcLoad,
    output logic      [PC_W-1:0] pcLoadAddr,
    output logic                 sleeping,
    // Status view
    output logic                 timeoutFlag,
    output logic                 powerdownFlag,
    output logic                 powerOnFlag,
    output logic                 brownoutFlag,
    output logic                 globalIrqEnable,
    output logic                 irq,
    // Wishbone slave
    input  wire logic            wb_cyc_i,
    input  wire logic            wb_stb_i,
    input  wire logic            wb_we_i,
    input  wire logic [7:0]      wb_adr_i,
    input  wire logic [3:0]      wb_sel_i,
    input  wire logic [31:0]     wb_dat_i,
    output logic      [31:0]     wb_dat_o,
    output logic                 wb_ack_o
);
    rcs_state_t              state_r;
    rcs_status_t             statusWord;
    logic                    toFlag_r;
    logic                    pdFlag_r;
    logic [2:0]              bank_r;
    logic [2:0]              alu_r;
    rcs_cause_t              cause;
    logic                    pwrOn_r;
    logic                    brownOut_r;
    logic [4:0]              pcHigh_r;
    logic [7:0]              irqCtrl_r;
    logic [7:0]              periph_irq_flags1_r;
    logic [7:0]              periph_irq_flags2_r;
    logic [7:0]              dataRegs [`RCS_DATA_REGS];
    logic [PC_W-1:0]         sleepPc_r;
    logic                    pcLoad_r;
    logic [PC_W-1:0]         pcLoadAddr_r;
    logic                    ack_r;
    logic [31:0]             rdData_r;
    logic [3:0]              regIdx;
    logic                    busWr;
    logic                    isSleep;
    logic                    resetHit;
    logic [`RCS_EVT_W-1:0]   evtStatus;
    logic [`RCS_EVT_W-1:0]   evtMask;
    logic [7:0]              rdMux;
    logic                    firstCyc_r;

    assign isSleep = (state_r == RCS_SLEEP);
    // Status byte assembled from its separately owned fields
    assign statusWord = {bank_r, toFlag_r, pdFlag_r, alu_r};
    assign regIdx  = wb_adr_i[5:2];
    // Write takes effect on the edge where the master sees ack
    assign busWr   = wb_cyc_i & wb_stb_i & wb_we_i & ack_r & wb_sel_i[0];

    // Cause resolution with fixed priority
    always_comb begin
        cause         = '0;
        cause.bor     = HAS_BOR & brownoutDetectEnable & borReq;
        cause.master_clear_pin    = masterClearReq & ~cause.bor;
        cause.wdtRst  = watchdogTimeout & ~isSleep & ~cause.bor & ~masterClearReq;
        cause.wdtWake = watchdogTimeout & isSleep & ~cause.bor & ~masterClearReq;
        cause.irqWake = irqWakeReq & isSleep & ~cause.bor & ~masterClearReq & ~watchdogTimeout;
    end
    assign resetHit = cause.bor | cause.master_clear_pin | cause.wdtRst;

    // Time-out and power-down flags
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            toFlag_r <= 1'b1;
            pdFlag_r <= 1'b1;
        end else if (cause.bor) begin
            toFlag_r <= 1'b1;
            pdFlag_r <= 1'b1;
        end else if (cause.master_clear_pin) begin
            if (isSleep) begin
                toFlag_r <= 1'b1;
                pdFlag_r <= 1'b0;
            end
        end else if (cause.wdtRst) begin
            toFlag_r <= 1'b0;
            pdFlag_r <= 1'b1;
        end else if (cause.wdtWake) begin
            toFlag_r <= 1'b0;
            pdFlag_r <= 1'b0;
        end else if (cause.irqWake || (sleepEnter && state_r == RCS_RUN)) begin
            toFlag_r <= 1'b1;
            pdFlag_r <= 1'b0;
        end
    end

    // Bank bits cleared by resets, others written by software
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bank_r <= 3'h0;
            alu_r  <= 3'h0;
        end else begin
            if (resetHit) begin
                bank_r <= 3'h0;
            end else if (busWr && regIdx == `RCS_OFF_STATUS) begin
                bank_r <= wb_dat_i[7:5];
            end
            if (busWr && regIdx == `RCS_OFF_STATUS) begin
                alu_r <= wb_dat_i[2:0];
            end
        end
    end

    // Power-on status bit, cleared by power-on, otherwise written by software
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pwrOn_r <= 1'b0;
        end else if (HAS_PWRCTL && busWr && regIdx == `RCS_OFF_PWRCTL) begin
            pwrOn_r <= wb_dat_i[`RCS_PC_POR];
        end
    end

    // Brown-out status bit, hardware clear wins over software write
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            brownOut_r <= 1'b0;
        end else if (!HAS_BOR || !HAS_PWRCTL) begin
            brownOut_r <= 1'b0;
        end else if (cause.bor) begin
            brownOut_r <= 1'b0;
        end else if (busWr && regIdx == `RCS_OFF_PWRCTL) begin
            brownOut_r <= wb_dat_i[`RCS_PC_BOR];
        end
    end

    // High latch and interrupt registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pcHigh_r  <= 5'h00;
            irqCtrl_r <= 8'h00;
            periph_irq_flags1_r    <= 8'h00;
            periph_irq_flags2_r    <= 8'h00;
        end else if (resetHit) begin
            pcHigh_r  <= 5'h00;
            irqCtrl_r <= {7'h00, irqCtrl_r[0]};
            periph_irq_flags1_r    <= 8'h00;
            periph_irq_flags2_r    <= 8'h00;
        end else begin
            if (busWr && regIdx == `RCS_OFF_PCHIGH) begin
                pcHigh_r <= wb_dat_i[4:0];
            end
            if (state_r == RCS_VECT && instrDone) begin
                irqCtrl_r[`RCS_IC_GIE] <= 1'b0;
            end else if (busWr && regIdx == `RCS_OFF_IRQCTL) begin
                irqCtrl_r <= wb_dat_i[7:0] | (cause.irqWake ? wakeIrqCtrlFlags : 8'h00);
            end else if (cause.irqWake) begin
                irqCtrl_r <= irqCtrl_r | wakeIrqCtrlFlags;
            end
            if (busWr && regIdx == `RCS_OFF_PERIPH_IRQ_FLAGS1) begin
                periph_irq_flags1_r <= wb_dat_i[7:0] | (cause.irqWake ? wakePir1Flags : 8'h00);
            end else if (cause.irqWake) begin
                periph_irq_flags1_r <= periph_irq_flags1_r | wakePir1Flags;
            end
            if (busWr && regIdx == `RCS_OFF_PERIPH_IRQ_FLAGS2) begin
                periph_irq_flags2_r <= wb_dat_i[7:0] | (cause.irqWake ? wakePir2Flags : 8'h00);
            end else if (cause.irqWake) begin
                periph_irq_flags2_r <= periph_irq_flags2_r | wakePir2Flags;
            end
        end
    end

    // Data registers without reset: unknown at power-on, kept otherwise
    for (genvar i = 0; i < `RCS_DATA_REGS; i++) begin : g_data
        always_ff @(posedge clk) begin
            if (busWr && regIdx == 4'(`RCS_OFF_DATA0 + i)) begin
                dataRegs[i] <= wb_dat_i[7:0];
            end
        end
    end

    // Sleep address capture
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sleepPc_r <= '0;
        end else if (sleepEnter && state_r == RCS_RUN && !resetHit) begin
            sleepPc_r <= pcNow;
        end
    end

    // Program counter sequencing
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r      <= RCS_RUN;
            pcLoad_r     <= 1'b0;
            pcLoadAddr_r <= PC_W'(`RCS_RST_VEC);
        end else begin
            pcLoad_r <= 1'b0;
            if (resetHit) begin
                state_r      <= RCS_RUN;
                pcLoad_r     <= 1'b1;
                pcLoadAddr_r <= PC_W'(`RCS_RST_VEC);
            end else begin
                unique case (state_r)
                    RCS_RUN: begin
                        if (sleepEnter) begin
                            state_r <= RCS_SLEEP;
                        end
                    end
                    RCS_SLEEP: begin
                        if (cause.wdtWake || cause.irqWake) begin
                            pcLoad_r     <= 1'b1;
                            pcLoadAddr_r <= sleepPc_r + PC_W'(1);
                            state_r      <= (cause.irqWake && irqCtrl_r[`RCS_IC_GIE]) ? RCS_VECT : RCS_RUN;
                        end
                    end
                    RCS_VECT: begin
                        if (instrDone) begin
                            pcLoad_r     <= 1'b1;
                            pcLoadAddr_r <= PC_W'(`RCS_IRQ_VEC);
                            state_r      <= RCS_RUN;
                        end
                    end
                endcase
            end
        end
    end

    // Event sticky bits and interrupt
    rcs_evt_irq #(
        .W (`RCS_EVT_W)
    ) u_evt (
        .clk       (clk),
        .rst_n     (rst_n),
        .evtSet    (cause),
        .clrWr     (busWr && regIdx == `RCS_OFF_EVTSTAT),
        .clrData   (wb_dat_i[`RCS_EVT_W-1:0]),
        .maskWr    (busWr && regIdx == `RCS_OFF_EVTMASK),
        .maskData  (wb_dat_i[`RCS_EVT_W-1:0]),
        .evtStatus (evtStatus),
        .evtMask   (evtMask),
        .irq       (irq)
    );

    // Read multiplexer, unmapped reads zero
    always_comb begin
        rdMux = 8'h00;
        if (regIdx >= `RCS_OFF_DATA0 && regIdx < 4'(`RCS_OFF_DATA0 + `RCS_DATA_REGS)) begin
            rdMux = dataRegs[2'(regIdx - `RCS_OFF_DATA0)];
        end else begin
            unique case (regIdx)
                `RCS_OFF_STATUS:  rdMux = statusWord;
                `RCS_OFF_PWRCTL:  rdMux = HAS_PWRCTL ? {6'h00, pwrOn_r, brownOut_r} : 8'h00;
                `RCS_OFF_PCHIGH:  rdMux = {3'h0, pcHigh_r};
                `RCS_OFF_IRQCTL:  rdMux = irqCtrl_r;
                `RCS_OFF_PERIPH_IRQ_FLAGS1:    rdMux = periph_irq_flags1_r;
                `RCS_OFF_PERIPH_IRQ_FLAGS2:    rdMux = periph_irq_flags2_r;
                `RCS_OFF_EVTSTAT: rdMux = {2'h0, evtStatus};
                `RCS_OFF_EVTMASK: rdMux = {2'h0, evtMask};
                default:          rdMux = 8'h00;
            endcase
        end
    end

    // Wishbone ack one cycle after request, dropped the cycle after
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_r    <= 1'b0;
            rdData_r <= 32'h0000_0000;
        end else begin
            ack_r    <= wb_cyc_i & wb_stb_i & ~ack_r;
            rdData_r <= {24'h00_0000, rdMux};
        end
    end

    // Helper for first cycle after power-on
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            firstCyc_r <= 1'b1;
        end else begin
            firstCyc_r <= 1'b0;
        end
    end

    assign wb_ack_o        = ack_r;
    assign wb_dat_o        = rdData_r;
    assign pcLoad          = pcLoad_r;
    assign pcLoadAddr      = pcLoadAddr_r;
    assign sleeping        = isSleep;
    assign timeoutFlag     = toFlag_r;
    assign powerdownFlag   = pdFlag_r;
    assign powerOnFlag     = HAS_PWRCTL & pwrOn_r;
    assign brownoutFlag    = brownOut_r;
    assign globalIrqEnable = irqCtrl_r[`RCS_IC_GIE];

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence irqWakeGie_s;
        cause.irqWake && irqCtrl_r[`RCS_IC_GIE];
    endsequence
    sequence nextInstr_s;
        pcLoad && pcLoadAddr == $past(sleepPc_r) + PC_W'(1) && state_r == RCS_VECT;
    endsequence

    por_timeout_a: assert property (firstCyc_r |-> timeoutFlag && !powerOnFlag)
        else $error("power-on flags wrong");
    por_powerdown_a: assert property (firstCyc_r |-> powerdownFlag)
        else $error("power-down not set at power-on");
    master_clear_pin_run_a: assert property (cause.master_clear_pin && !isSleep |=> pcLoad && pcLoadAddr == `RCS_RST_VEC
        && bank_r == 3'h0 && $stable(timeoutFlag) && $stable(powerdownFlag))
        else $error("pin reset in run wrong");
    master_clear_pin_sleep_a: assert property (cause.master_clear_pin && isSleep |=> pcLoad && timeoutFlag && !powerdownFlag)
        else $error("pin reset in sleep wrong");
    irq_wake_a: assert property (cause.irqWake |=> pcLoad && timeoutFlag && !powerdownFlag
        && pcLoadAddr == $past(sleepPc_r) + PC_W'(1))
        else $error("interrupt wake wrong");
    vector_entry_a: assert property (irqWakeGie_s |=> nextInstr_s)
        else $error("next instruction not run before vector");
    vector_seq_a: assert property (state_r == RCS_VECT && instrDone && !resetHit |=> pcLoad
        && pcLoadAddr == PC_W'(`RCS_IRQ_VEC) && !globalIrqEnable)
        else $error("interrupt vector not taken");
    wdt_reset_a: assert property (cause.wdtRst |=> pcLoad && !timeoutFlag && powerdownFlag
        && bank_r == 3'h0)
        else $error("watchdog reset wrong");
    wdt_wake_a: assert property (cause.wdtWake |=> !timeoutFlag && !powerdownFlag && !sleeping
        && $stable(bank_r))
        else $error("watchdog wake wrong");
    bor_reset_a: assert property (cause.bor |=> timeoutFlag && powerdownFlag && !brownoutFlag
        && $stable(powerOnFlag) && pcLoadAddr == `RCS_RST_VEC)
        else $error("brown-out reset wrong");
    no_bor_bit_a: assert property (!HAS_BOR |-> !brownoutFlag ##1 !brownoutFlag)
        else $error("absent brown-out bit set");
    core_clear_a: assert property (resetHit |=> pcHigh_r == 5'h00 && periph_irq_flags1_r == 8'h00
        && irqCtrl_r[7:1] == 7'h00 && irqCtrl_r[0] == $past(irqCtrl_r[0]))
        else $error("core registers not cleared");
    data_keep_a: assert property (resetHit |=> dataRegs[0] == $past(dataRegs[0]))
        else $error("data register changed by reset");
    cause_prio_a: assert property (cause.bor && masterClearReq |=> powerdownFlag && timeoutFlag)
        else $error("cause priority wrong");
endmodule // rcs_reset_cause

// file: tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import rcs_pkg::*;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        brownEn = 1'b1;
    logic [5:0]  ctl = 6'h00;
    logic [7:0]  wIrq = 8'h00, wP1 = 8'h00, wP2 = 8'h00;
    logic [12:0] pcNow = 13'h0123;
    logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] datI = 32'h0, datO, rd;
    logic        ack, pcLoad, sleeping, toF, pdF, porF, borF, global_irq_enable, irq;
    logic [12:0] pcAddr;
    logic        porB, borB;
    logic [31:0] datB;
    int          failCount = 0;
    int          testsRun = 0;
    // Cause pulse codes on ctl
    localparam logic [5:0] C_SLEEP = 6'h01, C_BROWN = 6'h02, C_PIN = 6'h04;
    localparam logic [5:0] C_DOG = 6'h08, C_WAKE = 6'h10, C_DONE = 6'h20;

    // 100 ns clock
    always #50 clk = ~clk;

    rcs_reset_cause dut_u (
        .clk(clk), .rst_n(rst_n), .borReq(ctl[1]), .brownoutDetectEnable(brownEn),
        .masterClearReq(ctl[2]), .watchdogTimeout(ctl[3]), .irqWakeReq(ctl[4]),
        .wakeIrqCtrlFlags(wIrq), .wakePir1Flags(wP1), .wakePir2Flags(wP2),
        .sleepEnter(ctl[0]), .pcNow(pcNow), .instrDone(ctl[5]), .pcLoad(pcLoad),
        .pcLoadAddr(pcAddr), .sleeping(sleeping), .timeoutFlag(toF), .powerdownFlag(pdF),
        .powerOnFlag(porF), .brownoutFlag(borF), .globalIrqEnable(global_irq_enable), .irq(irq),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1),
        .wb_dat_i(datI), .wb_dat_o(datO), .wb_ack_o(ack)
    );

    // Smallest variant: no power control register, no brown-out bit
    rcs_reset_cause #(
        .HAS_PWRCTL (1'b0),
        .HAS_BOR    (1'b0)
    ) dutSmall_u (
        .clk(clk), .rst_n(rst_n), .borReq(ctl[1]), .brownoutDetectEnable(brownEn),
        .masterClearReq(ctl[2]), .watchdogTimeout(ctl[3]), .irqWakeReq(ctl[4]),
        .wakeIrqCtrlFlags(wIrq), .wakePir1Flags(wP1), .wakePir2Flags(wP2),
        .sleepEnter(ctl[0]), .pcNow(pcNow), .instrDone(ctl[5]), .pcLoad(),
        .pcLoadAddr(), .sleeping(), .timeoutFlag(), .powerdownFlag(),
        .powerOnFlag(porB), .brownoutFlag(borB), .globalIrqEnable(), .irq(),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1),
        .wb_dat_i(datI), .wb_dat_o(datB), .wb_ack_o()
    );

    // Verdict and end of run
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", testsRun, failCount);
        if (failCount == 0 && testsRun > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // One compare
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        testsRun++;
        if (got !== exp) begin
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
            failCount++;
        end
    endtask

    // Classic single Wishbone cycle, bounded wait for ack
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        @(posedge clk);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; datI <= {24'h0, d};
        for (n = 0; n < 20; n++) begin
            @(posedge clk);
            if (ack === 1'b1) break;
        end
        if (n == 20) begin
            failCount++;
            summarize();
        end
        rd = datO;
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
        wb(1'b0, a, 8'h00);
        chk(rd, {24'h0, exp});
    endtask

    // One-cycle cause pulse, then check the registered answer
    task automatic cause(input logic [5:0] c, input logic expLoad, input logic [12:0] expAddr);
        @(posedge clk);
        ctl <= c;
        @(posedge clk);
        ctl <= 6'h00;
        #1;
        chk(pcLoad, expLoad);
        if (expLoad) chk(pcAddr, expAddr);
    endtask

    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        chk(toF, 1'b1);
        chk(pdF, 1'b1);
        chk(porF, 1'b0);
        rdChk(8'h28, 8'h01);
        rdChk(8'h0C, 8'h00);
        wb(1'b1, 8'h04, 8'h03);
        rdChk(8'h04, 8'h03);
        chk({porB, borB}, 2'b00);
        chk(datB, 32'h0000_0000);
        wb(1'b1, 8'h00, 8'hFF);
        rdChk(8'h00, 8'hFF);
        wb(1'b1, 8'h18, 8'h5A);
        wb(1'b1, 8'h08, 8'h1F);
        wb(1'b1, 8'h0C, 8'h80);
        // Pin reset while running
        cause(C_PIN, 1'b1, 13'h0000);
        rdChk(8'h00, 8'h1F);
        rdChk(8'h08, 8'h00);
        rdChk(8'h0C, 8'h00);
        rdChk(8'h18, 8'h5A);
        chk(porF, 1'b1);
        // Watchdog reset while running
        cause(C_DOG, 1'b1, 13'h0000);
        rdChk(8'h00, 8'h0F);
        // Pin reset during sleep
        wb(1'b1, 8'h00, 8'hA5);
        cause(C_SLEEP, 1'b0, 13'h0000);
        chk(sleeping, 1'b1);
        cause(C_PIN, 1'b1, 13'h0000);
        rdChk(8'h00, 8'h15);
        // Watchdog wake
        wb(1'b1, 8'h00, 8'hA5);
        cause(C_SLEEP, 1'b0, 13'h0000);
        cause(C_DOG, 1'b1, 13'h0124);
        rdChk(8'h00, 8'hA5);
        // Interrupt wake, global enable off
        wb(1'b1, 8'h08, 8'h15);
        wIrq <= 8'h04;
        wP1 <= 8'h10;
        wP2 <= 8'h01;
        cause(C_SLEEP, 1'b0, 13'h0000);
        cause(C_WAKE, 1'b1, 13'h0124);
        rdChk(8'h00, 8'hB5);
        rdChk(8'h0C, 8'h04);
        rdChk(8'h10, 8'h10);
        rdChk(8'h14, 8'h01);
        rdChk(8'h08, 8'h15);
        // Interrupt wake with vectoring
        wb(1'b1, 8'h0C, 8'h80);
        cause(C_SLEEP, 1'b0, 13'h0000);
        cause(C_WAKE, 1'b1, 13'h0124);
        cause(C_DONE, 1'b1, 13'h0004);
        chk(global_irq_enable, 1'b0);
        // Brown-out request with detection disabled
        brownEn <= 1'b0;
        cause(C_BROWN, 1'b0, 13'h0000);
        chk(borF, 1'b1);
        brownEn <= 1'b1;
        // Brown-out reset
        wb(1'b1, 8'h00, 8'hE0);
        cause(C_BROWN, 1'b1, 13'h0000);
        chk(borF, 1'b0);
        chk(porF, 1'b1);
        rdChk(8'h00, 8'h18);
        // Simultaneous causes and event interrupt
        wb(1'b1, 8'h28, 8'h3F);
        rdChk(8'h28, 8'h00);
        wb(1'b1, 8'h04, 8'h03);
        cause(C_BROWN | C_PIN | C_DOG, 1'b1, 13'h0000);
        rdChk(8'h28, 8'h02);
        chk({toF, pdF, borF}, 3'b110);
        chk(irq, 1'b0);
        wb(1'b1, 8'h2C, 8'h02);
        chk(irq, 1'b1);
        wb(1'b1, 8'h2C, 8'h00);
        chk(irq, 1'b0);
        wb(1'b1, 8'h2C, 8'h02);
        wb(1'b1, 8'h28, 8'h02);
        chk(irq, 1'b0);
        // Unmapped place
        wb(1'b1, 8'h30, 8'hAA);
        rdChk(8'h30, 8'h00);
        // Power-on reset in mid-run
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        chk({toF, pdF, porF}, 3'b110);
        rst_n <= 1'b1;
        summarize();
    end
endmodule // tb_top
